// File: sysref_window_regs.svh
/*
 * register indices, byte addresses, field positions, reset values and
 * sizes of the sysref window detector.
 * assumes a 32-bit avalon-mm slave with one register per aligned word.
 */
`ifndef SYSREF_WINDOW_REGS_SVH
`define SYSREF_WINDOW_REGS_SVH

// ********************************************************
// register indices and byte addresses
// ********************************************************
`define SWD_IDX_STATUS_LOW   12'h090
`define SWD_IDX_STATUS_MID   12'h091
`define SWD_IDX_STATUS_HIGH  12'h092
`define SWD_IDX_CONTROL      12'h093
`define SWD_ADDR_STATUS_LOW  12'h240
`define SWD_ADDR_STATUS_MID  12'h244
`define SWD_ADDR_STATUS_HIGH 12'h248
`define SWD_ADDR_CONTROL     12'h24C

// ********************************************************
// control register fields
// ********************************************************
`define SWD_CTL_SEL_LSB      0
`define SWD_CTL_SEL_MSB      3
`define SWD_CTL_FINE_BIT     4
`define SWD_CTL_PERSIST_BIT  5
`define SWD_CTL_PROC_BIT     6
`define SWD_CTL_ALIGN_BIT    7
`define SWD_CTL_SLEEP_BIT    8
`define SWD_CTL_WIDTH        9
`define SWD_CTL_RESET        9'h110

// ********************************************************
// sizes
// ********************************************************
`define SWD_POSITIONS        20
`define SWD_EDGE_MASK        20'h80001

`endif

// File: sysref_window_pkg.sv
/*
 * types shared by the sysref window detector and its sampler.
 * assumes sysref_window_regs.svh is on the include path.
 */
`default_nettype none
`include "sysref_window_regs.svh"

package sysref_window_pkg;

   // ********************************************************
   // types
   // ********************************************************
   typedef logic [`SWD_POSITIONS-1:0] window_t;   // one bit per position
   typedef logic [3:0]                sel_t;      // selectable index 0..15
   typedef logic [`SWD_CTL_WIDTH-1:0] ctrl_t;     // control register

   // bus handshake phase
   typedef enum logic [0:0]
   {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;

endpackage : sysref_window_pkg

`default_nettype wire

// File: window_sampler.sv
/*
 * sampler: synchronises the delay-tap snapshot of sysref, spots each
 * sysref arrival while not asleep and builds the window status, fresh or sticky.
 * assumes the tap snapshot comes from an analog delay line (async).
 */
`timescale 1ns/100ps
`default_nettype none

module window_sampler
   import sysref_window_pkg::*;
(
   input  wire logic                     clk,        // core clock
   input  wire logic                     reset,      // sync, active high
   input  wire sysref_window_pkg::window_t taps_in,  // raw tap samples
   input  wire logic                     persist_en, // sticky mode
   input  wire logic                     sleep,      // receiver asleep
   output var   sysref_window_pkg::window_t tap_sync, // synced taps
   output var   sysref_window_pkg::window_t status    // window status
);
   import sysref_window_pkg::*;

   // ********************************************************
   // synchroniser and edge detect
   // ********************************************************
   window_t meta_q;      // first stage, read only by sync_q
   window_t sync_q;      // second stage
   window_t prev_q;      // previous synced snapshot
   window_t acc_q;       // accumulated / latest result
   logic    persist_q;   // persistence enable, delayed
   logic    arrival;     // sysref arrived this cycle
   window_t raw;         // flags from current snapshot

   // marks positions next to a 0/1 boundary in the snapshot
   function automatic window_t flag_boundary(input window_t s);
      window_t r;
      r = '0;
      for (int i = 0; i < `SWD_POSITIONS; i++)
      begin
         if (i > 0)
            r[i] = r[i] | (s[i] ^ s[i-1]);
         if (i < `SWD_POSITIONS-1)
            r[i] = r[i] | (s[i] ^ s[i+1]);
      end
      return r;
   endfunction : flag_boundary

   // two flops before anything looks at the taps
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= taps_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign arrival  = (prev_q == '0) && (sync_q != '0) && !sleep;
   assign raw      = flag_boundary(sync_q);
   assign tap_sync = sync_q;

   // ********************************************************
   // window accumulation
   // ********************************************************
   // fresh result per arrival, or sticky or-ing since enable rose
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         acc_q     <= '0;
         persist_q <= 1'b0;
      end
      else
      begin
         persist_q <= persist_en;
         if (persist_en && !persist_q)
            acc_q <= arrival ? raw : '0;
         else if (arrival && persist_en)
            acc_q <= acc_q | raw;
         else if (arrival)
            acc_q <= raw;
      end
   end

   // outermost positions can never be judged
   assign status = acc_q | `SWD_EDGE_MASK;

   // ********************************************************
   // checks
   // ********************************************************
   a_edge_bits_set: assert property (
      @(posedge clk) disable iff (reset) status[0] && status[19])
      else $error("outer window bits not set");

   a_fresh_replace: assert property (
      @(posedge clk) disable iff (reset)
      arrival && !persist_en && persist_q == persist_en
      |=> acc_q == $past(raw))
      else $error("fresh window not replaced");

   a_sticky_keep: assert property (
      @(posedge clk) disable iff (reset)
      persist_en && persist_q ##1 persist_en
      |-> (acc_q & $past(acc_q)) == $past(acc_q))
      else $error("sticky bit lost");

   a_flag_boundary: assert property (
      @(posedge clk) disable iff (reset)
      arrival |=> (status & $past(raw)) == $past(raw))
      else $error("boundary position not flagged");

endmodule : window_sampler

`default_nettype wire

// File: sysref_window_detector.sv
/*
 * sysref window detector: avalon-mm register slave, window status,
 * sample point selection and gated sysref capture.
 * assumes the delay line outside applies FINE_STEP to its spacing and
 * delivers one sample of sysref per tap on TAP_SAMPLES.
 */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module sysref_window_detector
   import sysref_window_pkg::*;
(
   input  wire logic                       CORE_CLK,         // 100 MHz
   input  wire logic                       RESET,            // sync, high
   input  wire logic [11:0]                AVS_ADDRESS,      // byte addr
   input  wire logic                       AVS_READ,         // read req
   input  wire logic                       AVS_WRITE,        // write req
   input  wire logic [31:0]                AVS_WRITEDATA,    // write data
   input  wire logic [3:0]                 AVS_BYTEENABLE,   // lanes
   output logic      [31:0]                AVS_READDATA,     // read data
   output logic                            AVS_WAITREQUEST,  // stall
   input  wire sysref_window_pkg::window_t TAP_SAMPLES,      // delay taps
   output logic                            FINE_STEP,        // tap spacing
   output logic                            RECEIVER_SLEEP,   // rx asleep
   output logic                            PROCESS_ENABLE,   // sysref used
   output logic                            ALIGN_ENABLE,     // clk align
   output logic                            SYSREF_OUT        // captured
);
   import sysref_window_pkg::*;

   // ********************************************************
   // declarations
   // ********************************************************
   bus_state_t bus_q;          // handshake phase
   logic       wait_q;         // waitrequest flop
   logic [31:0] rdata_q;       // read data flop
   ctrl_t      ctrl_q;         // control register
   logic       sysref_q;       // captured sysref
   window_t    tap_sync;       // synchronised taps
   window_t    status;         // window status
   sel_t       sel;            // selected position
   logic       request;        // read or write pending
   logic       accept;         // request taken this edge
   logic       hit_ctrl;       // address is control register
   logic       ctrl_wr;        // control write lands this edge
   logic       rd_idle;        // read seen while slave idle

   assign sel      = ctrl_q[`SWD_CTL_SEL_MSB:`SWD_CTL_SEL_LSB];
   assign request  = AVS_READ | AVS_WRITE;
   assign accept   = request && (bus_q == BUS_ANSWER);
   assign hit_ctrl = (AVS_ADDRESS == `SWD_ADDR_CONTROL);
   assign ctrl_wr  = accept && AVS_WRITE && hit_ctrl;
   assign rd_idle  = AVS_READ && (bus_q == BUS_IDLE);

   // ********************************************************
   // window sampler
   // ********************************************************
   window_sampler u_sampler
   (
      .clk        (CORE_CLK),
      .reset      (RESET),
      .taps_in    (TAP_SAMPLES),
      .persist_en (ctrl_q[`SWD_CTL_PERSIST_BIT]),
      .sleep      (ctrl_q[`SWD_CTL_SLEEP_BIT]),
      .tap_sync   (tap_sync),
      .status     (status)
   );

   // ********************************************************
   // read decode
   // ********************************************************
   // register contents for a byte address; unmapped reads as zero
   function automatic logic [31:0] read_value(
      input logic [11:0] addr,
      input window_t     st,
      input ctrl_t       c
   );
      logic [31:0] v;
      v = '0;
      unique case (addr)
         `SWD_ADDR_STATUS_LOW:  v[7:0] = st[7:0];
         `SWD_ADDR_STATUS_MID:  v[7:0] = st[15:8];
         `SWD_ADDR_STATUS_HIGH: v[3:0] = st[19:16];
         `SWD_ADDR_CONTROL:     v[`SWD_CTL_WIDTH-1:0] = c;
         default:               v = '0;
      endcase
      return v;
   endfunction : read_value

   // ********************************************************
   // bus handshake
   // ********************************************************
   // one wait cycle: request seen in idle, answered at the next edge
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         bus_q  <= BUS_IDLE;
         wait_q <= 1'b1;
      end
      else
      begin
         unique case (bus_q)
            BUS_IDLE:
            begin
               if (request)
               begin
                  bus_q  <= BUS_ANSWER;
                  wait_q <= 1'b0;
               end
            end
            BUS_ANSWER:
            begin
               bus_q  <= BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // read data loaded as waitrequest drops, held until next read
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         rdata_q <= '0;
      else if (rd_idle)
         rdata_q <= read_value(AVS_ADDRESS, status, ctrl_q);
   end

   // ********************************************************
   // control register
   // ********************************************************
   // written only at the edge where waitrequest is seen low
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         ctrl_q <= `SWD_CTL_RESET;
      else if (ctrl_wr)
      begin
         if (AVS_BYTEENABLE[0])
            ctrl_q[7:0] <= AVS_WRITEDATA[7:0];
         if (AVS_BYTEENABLE[1])
            ctrl_q[8] <= AVS_WRITEDATA[8];
      end
   end

   // ********************************************************
   // sysref capture
   // ********************************************************
   // only four select bits exist, so positions 16..19 are unreachable
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         sysref_q <= 1'b0;
      else
         sysref_q <= tap_sync[sel] & ctrl_q[`SWD_CTL_PROC_BIT];
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign FINE_STEP       = ctrl_q[`SWD_CTL_FINE_BIT];
   assign RECEIVER_SLEEP  = ctrl_q[`SWD_CTL_SLEEP_BIT];
   assign PROCESS_ENABLE  = ctrl_q[`SWD_CTL_PROC_BIT];
   assign ALIGN_ENABLE    = ctrl_q[`SWD_CTL_ALIGN_BIT];
   assign SYSREF_OUT      = sysref_q;

   // ********************************************************
   // checks
   // ********************************************************
   a_capture_selected: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      1'b1 |=> SYSREF_OUT == $past(tap_sync[sel] && PROCESS_ENABLE))
      else $error("sysref not captured at selected tap");

   a_gate_closed: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      !PROCESS_ENABLE ##1 !PROCESS_ENABLE |-> !SYSREF_OUT)
      else $error("sysref passed while processing disabled");

   a_select_index: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      accept && AVS_WRITE && hit_ctrl && AVS_BYTEENABLE[0]
      |=> sel == $past(AVS_WRITEDATA[3:0]))
      else $error("select field does not hold written index");

   a_fine_follows: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      accept && AVS_WRITE && hit_ctrl && AVS_BYTEENABLE[0]
      |=> FINE_STEP == $past(AVS_WRITEDATA[4]))
      else $error("fine step output not following control");

   a_high_width: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      bus_q == BUS_IDLE && AVS_READ && AVS_ADDRESS == `SWD_ADDR_STATUS_HIGH
      |=> AVS_READDATA[31:4] == '0 && !AVS_WAITREQUEST)
      else $error("high status word wider than four bits");

   a_wait_one: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      request && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("waitrequest not low for exactly one cycle");

   a_status_read: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      bus_q == BUS_IDLE && AVS_READ && AVS_ADDRESS == `SWD_ADDR_STATUS_LOW
      |=> AVS_READDATA[7:0] == $past(status[7:0]))
      else $error("low status read mismatch");

   // ********************************************************
   // read path, control register and waitrequest checks
   // ********************************************************
   // middle status word carries positions 15..8 and nothing more
   a_mid_read: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      rd_idle && AVS_ADDRESS == `SWD_ADDR_STATUS_MID
      |=> AVS_READDATA == {24'h0, $past(status[15:8])})
      else $error("middle status read mismatch");

   // position 0 reads as flagged through the bus
   a_edge_low_read: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      rd_idle && AVS_ADDRESS == `SWD_ADDR_STATUS_LOW
      |=> AVS_READDATA[0])
      else $error("position zero not flagged on read");

   // position 19 reads as flagged through the bus
   a_edge_high_read: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      rd_idle && AVS_ADDRESS == `SWD_ADDR_STATUS_HIGH
      |=> AVS_READDATA[3])
      else $error("position nineteen not flagged on read");

   // control register reads back as stored
   a_ctrl_readback: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      rd_idle && hit_ctrl
      |=> AVS_READDATA == {23'h0, $past(ctrl_q)})
      else $error("control read back mismatch");

   // holes in the map read as zero
   a_unmapped_zero: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      rd_idle && !hit_ctrl
      && AVS_ADDRESS != `SWD_ADDR_STATUS_LOW
      && AVS_ADDRESS != `SWD_ADDR_STATUS_MID
      && AVS_ADDRESS != `SWD_ADDR_STATUS_HIGH
      |=> AVS_READDATA == '0)
      else $error("unmapped read not zero");

   // control changes only at an accepted control write
   a_ctrl_hold: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      !ctrl_wr |=> $stable(ctrl_q))
      else $error("control changed without a write");

   // process enable follows its written bit
   a_proc_follows: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      ctrl_wr && AVS_BYTEENABLE[0]
      |=> PROCESS_ENABLE == $past(AVS_WRITEDATA[`SWD_CTL_PROC_BIT]))
      else $error("process enable not following control");

   // alignment enable follows its written bit
   a_align_follows: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      ctrl_wr && AVS_BYTEENABLE[0]
      |=> ALIGN_ENABLE == $past(AVS_WRITEDATA[`SWD_CTL_ALIGN_BIT]))
      else $error("alignment enable not following control");

   // receiver sleep follows the second byte lane
   a_sleep_follows: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      ctrl_wr && AVS_BYTEENABLE[1]
      |=> RECEIVER_SLEEP == $past(AVS_WRITEDATA[`SWD_CTL_SLEEP_BIT]))
      else $error("receiver sleep not following control");

   // read data holds while no read is being taken
   a_rdata_hold: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      bus_q == BUS_IDLE && !AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data changed without a read");

   // idle slave without a request keeps waitrequest high
   a_wait_idle: assert property (
      @(posedge CORE_CLK) disable iff (RESET)
      bus_q == BUS_IDLE && !request |=> AVS_WAITREQUEST)
      else $error("waitrequest dropped without a request");

endmodule : sysref_window_detector

`default_nettype wire

// File: sysref_source.sv
/*
 * partner: clock source that drives one sysref pulse into the taps.
 * assumes the bench fires a pulse only while busy is low.
 */
`timescale 1ns/100ps
`default_nettype none

module sysref_source
   import sysref_window_pkg::*;
(
   input  wire logic                       clk,     // core clock
   input  wire logic                       reset,   // sync, high
   input  wire logic                       fire,    // start a pulse
   input  wire sysref_window_pkg::window_t pattern, // taps seen high
   output var   sysref_window_pkg::window_t taps,   // to the taps
   output logic                            busy     // pulse in flight
);
   import sysref_window_pkg::*;

   logic [3:0] cnt_q; // cycles left of pulse plus gap

   // ******
   // pulse, then a quiet gap so the next rise counts
   // ******
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         taps  <= '0;
         cnt_q <= 4'h0;
      end
      else if (fire)
      begin
         taps  <= pattern; // clock and sysref applied
         cnt_q <= 4'hC;
      end
      else if (cnt_q != 4'h0)
      begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h5)
            taps <= '0; // all taps low between pulses
      end
   end

   assign busy = fire | (cnt_q != 4'h0); // pulse or gap still running

endmodule : sysref_source

`default_nettype wire

// File: tb_top.sv
/*
 * bench: drives registers over avalon-mm and sysref via the partner,
 * checks status, controls and captured sysref.
 * assumes the design files and regs header are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sysref_window_regs.svh"

module tb_top;
   import sysref_window_pkg::*;
   logic        clk, rst, rd, wr, fire, busy, sysout, fine, slp, sd;
   logic [11:0] addr;     // bus address
   logic        wrq, pe, ae; // waitrequest, process, align
   logic [31:0] wdata, q, rdat; // bus data, result, read data
   logic [3:0]  be;       // byte lanes
   window_t     pat, taps, s, acc, p;
   logic [31:0] seed, error_cnt, checks_done, cyc;

   sysref_window_detector dut (.CORE_CLK(clk), .RESET(rst),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wrq), .TAP_SAMPLES(taps), .FINE_STEP(fine),
      .RECEIVER_SLEEP(slp), .PROCESS_ENABLE(pe), .ALIGN_ENABLE(ae),
      .SYSREF_OUT(sysout));
   sysref_source src (.clk(clk), .reset(rst), .fire(fire),
      .pattern(pat), .taps(taps), .busy(busy));

   // ******
   // helpers
   // ******
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // edges of the pattern flagged, outer bits forced
   function automatic window_t win(input window_t t);
      window_t w;
      w = `SWD_EDGE_MASK;
      for (int i = 1; i < 19; i++)
         w[i] = (t[i] != t[i-1]) | (t[i] != t[i+1]);
      return w;
   endfunction : win

   task automatic chk(input logic [31:0] seen, exp, input string m);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done != 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] r);
      @(posedge clk);
      rd <= !w; wr <= w; addr <= a; wdata <= d; be <= b;
      // no cycle limit here; the bench timeout ends a wait that never sees waitrequest low
      do
      begin
         @(posedge clk);
      end
      while (wrq !== 1'b0);
      r = rdat;
      rd <= 1'b0; wr <= 1'b0;
   endtask : bus

   task automatic rd_status(output window_t w);
      logic [31:0] r;
      bus(0, `SWD_ADDR_STATUS_LOW, 0, 4'hF, r);
      w[7:0] = r[7:0];
      bus(0, `SWD_ADDR_STATUS_MID, 0, 4'hF, r);
      w[15:8] = r[7:0];
      bus(0, `SWD_ADDR_STATUS_HIGH, 0, 4'hF, r);
      w[19:16] = r[3:0];
   endtask : rd_status

   task automatic ctl(input logic [8:0] v);
      logic [31:0] r;
      bus(1, `SWD_ADDR_CONTROL, {23'h0, v}, 4'hF, r);
      @(posedge clk); // control outputs settle one edge after the write
   endtask : ctl

   // one sysref pulse; captured output sampled mid pulse
   task automatic pulse(input window_t t, output logic seen);
      int n;
      @(posedge clk);
      fire <= 1'b1; pat <= t;
      @(posedge clk);
      fire <= 1'b0;
      repeat (5) @(posedge clk);
      seen = sysout;
      n = 0;
      while (busy !== 1'b0 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
   endtask : pulse

   // ******
   // clock and timeout
   // ******
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end

   // ******
   // main sequence
   // ******
   initial
   begin
      rst = 1; rd = 0; wr = 0; addr = 0; wdata = 0; be = 4'hF;
      fire = 0; pat = 0; seed = 32'h51f3a0ed;
      error_cnt = 0; checks_done = 0; cyc = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // reset values, sleeping receiver ignores sysref
      bus(0, `SWD_ADDR_CONTROL, 0, 4'hF, q);
      chk(q, 32'h110, "control reset");
      pulse(20'h000FF, sd);
      rd_status(s);
      chk(s, 20'h80001, "status at reset");
      chk(fine, 1'b1, "fine after reset");
      chk(slp, 1'b1, "sleep after reset");
      $display("test reset done");
      // read-only status, unmapped place, byte lanes
      bus(1, `SWD_ADDR_STATUS_LOW, 32'hFF, 4'hF, q);
      bus(0, `SWD_ADDR_STATUS_LOW, 0, 4'hF, q);
      chk(q, 32'h01, "status written");
      bus(0, 12'h300, 0, 4'hF, q);
      chk(q, 32'h0, "unmapped read");
      bus(1, `SWD_ADDR_CONTROL, 32'hFFFFFFFF, 4'h1, q);
      bus(1, `SWD_ADDR_CONTROL, 32'h0, 4'h2, q);
      bus(0, `SWD_ADDR_CONTROL, 0, 4'hF, q);
      chk(q, 32'h0FF, "lane writes");
      ctl(9'h000); // coarse steps as a retry would use
      chk(fine, 1'b0, "coarse step");
      $display("test registers done");
      // fresh mode: each arrival replaces the status
      ctl(9'h010); // awake, fine steps
      chk(slp, 1'b0, "receiver awake");
      for (int k = 0; k < 10; k++)
      begin
         p = (k == 0) ? 20'h000FF : (k == 1) ? 20'hFFFFF : window_t'(rnd());
         p[k] = 1'b1;
         pulse(p, sd);
         rd_status(s);
         chk(s, win(p), "fresh status");
      end
      $display("test fresh done");
      // persistence: restart, then flags accumulate
      ctl(9'h030); // restart accumulation
      acc = `SWD_EDGE_MASK;
      for (int k = 0; k < 6; k++)
      begin
         p = window_t'(rnd()) | 20'h1;
         acc = acc | win(p);
         pulse(p, sd);
         rd_status(s);
         chk(s, acc, "sticky status");
      end
      ctl(9'h010);
      pulse(20'h00F00, sd);
      rd_status(s);
      chk(s, win(20'h00F00), "sticky off");
      $display("test persistence done");
      // every select value steers the captured sysref
      for (int n = 0; n < 16; n++)
      begin
         ctl({5'h01, n[3:0]}); // process off, new select
         chk(pe, 1'b0, "process off");
         ctl({5'h0D, n[3:0]}); // process and align on
         chk(pe, 1'b1, "process on");
         chk(ae, 1'b1, "align on");
         pulse(20'h1 << n, sd);
         chk(sd, 1'b1, "selected tap");
         pulse(20'h1 << (n + 1), sd);
         chk(sd, 1'b0, "other tap");
      end
      ctl(9'h017); // select the pulsed position 7, process off
      chk(ae, 1'b0, "align off");
      pulse(20'h00080, sd);
      chk(sd, 1'b0, "gated capture");
      $display("test select done");
      summarize();
   end

endmodule : tb_top

`default_nettype wire
